// *** src/sesacc_core.sv ***
`include "sesacc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sesacc_core #(
    // arbitrary neutral identity values
    parameter logic [63:0] MAKER_NAME  = "ACME LAB",
    parameter logic [31:0] MODEL_STEM  = "ACS-",
    parameter logic [39:0] MODEL_TAIL  = "010.1",
    parameter logic [7:0]  SERIAL_CHAR = "0"
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        CMD_VALID,
    input  wire logic [3:0]  CMD_CODE,
    input  wire logic [7:0]  CMD_ARG,
    output var  logic        CMD_READY,
    input  wire logic        OP_BUSY,
    input  wire logic        EVT_CME,
    input  wire logic        EVT_EXE,
    input  wire logic        EVT_DDE,
    input  wire logic        EVT_QYE,
    input  wire logic        CFG_PHASE_PROG,
    input  wire logic        CFG_POWER_READ,
    input  wire logic        CFG_DUAL_RANGE,
    input  wire logic [15:0] MAIN_REV_BCD,
    input  wire logic [15:0] BUS_REV_BCD,
    output var  logic        RSP_VALID,
    output var  logic [7:0]  RSP_DATA,
    output var  logic        RSP_LAST,
    output var  logic        EVENT_SUMMARY,
    output var  logic        STATUS_CLEAR,
    output var  logic        ENABLES_CLEAR,
    output var  logic        DFLT_LOAD,
    output var  logic        OUT_ON,
    output var  logic        RANGE_HIGH,
    output var  logic [15:0] FREQ_X10,
    output var  logic [15:0] PHASE_B_X10,
    output var  logic [15:0] PHASE_C_X10
);

    function automatic logic [7:0] ascii_digit(input logic [3:0] d);
        ascii_digit = {4'h3, d};
    endfunction

    sesacc_pkg::sesacc_state_t st_r, st_nxt;
    logic [7:0] ese_r, ese_nxt;
    logic [7:0] esr_r, esr_nxt;
    logic       esb_r;
    logic [5:0] idx_r, idx_nxt;
    logic [7:0] idn_char;
    logic       rsp_valid_nxt, rsp_last_nxt;
    logic [7:0] rsp_data_nxt;

    wire acc      = CMD_VALID && CMD_READY;
    wire is_ese_w = acc && (CMD_CODE == sesacc_pkg::SESACC_CMD_ESE_W);
    wire is_ese_q = acc && (CMD_CODE == sesacc_pkg::SESACC_CMD_ESE_Q);
    wire is_esr_q = acc && (CMD_CODE == sesacc_pkg::SESACC_CMD_ESR_Q);
    wire is_idn_q = acc && (CMD_CODE == sesacc_pkg::SESACC_CMD_IDN_Q);
    wire is_opc   = acc && (CMD_CODE == sesacc_pkg::SESACC_CMD_OPC);
    wire is_opc_q = acc && (CMD_CODE == sesacc_pkg::SESACC_CMD_OPC_Q);
    wire is_rst   = acc && (CMD_CODE == sesacc_pkg::SESACC_CMD_RST);
    wire is_cls   = acc && (CMD_CODE == sesacc_pkg::SESACC_CMD_CLS);

    wire opc_done  = (st_r == sesacc_pkg::SESACC_ST_OPCW) && !OP_BUSY;
    wire opcq_done = (st_r == sesacc_pkg::SESACC_ST_OPCQW) && !OP_BUSY;
    wire idn_end   = (st_r == sesacc_pkg::SESACC_ST_IDN) && (idx_r == `SESACC_IDN_LAST);

    // only documented bits can be set
    wire [7:0] evt_set = (8'(EVT_CME) << `SESACC_BIT_CME) | (8'(EVT_EXE) << `SESACC_BIT_EXE)
                       | (8'(EVT_DDE) << `SESACC_BIT_DDE) | (8'(EVT_QYE) << `SESACC_BIT_QYE)
                       | (8'(opc_done) << `SESACC_BIT_OPC);

    // read clears, but a same-cycle event survives
    // reset command does not touch the latch
    assign esr_nxt = ((is_esr_q || is_cls) ? 8'h00 : esr_r) | evt_set;

    // enable written whole, cleared by reset command
    assign ese_nxt = is_rst ? `SESACC_ESE_RESET : (is_ese_w ? CMD_ARG : ese_r);

    // serial execution: wait states hold off new commands
    always_comb begin
        case (st_r)
            sesacc_pkg::SESACC_ST_IDLE: begin
                if (is_opc)
                    st_nxt = sesacc_pkg::SESACC_ST_OPCW;
                else if (is_opc_q)
                    st_nxt = sesacc_pkg::SESACC_ST_OPCQW;
                else if (is_idn_q)
                    st_nxt = sesacc_pkg::SESACC_ST_IDN;
                else
                    st_nxt = sesacc_pkg::SESACC_ST_IDLE;
            end
            sesacc_pkg::SESACC_ST_OPCW:  st_nxt = OP_BUSY ? st_r : sesacc_pkg::SESACC_ST_IDLE;
            sesacc_pkg::SESACC_ST_OPCQW: st_nxt = OP_BUSY ? st_r : sesacc_pkg::SESACC_ST_IDLE;
            sesacc_pkg::SESACC_ST_IDN:   st_nxt = idn_end ? sesacc_pkg::SESACC_ST_IDLE : st_r;
            default:                     st_nxt = sesacc_pkg::SESACC_ST_IDLE;
        endcase
    end

    assign idx_nxt = (st_r == sesacc_pkg::SESACC_ST_IDN && !idn_end) ? idx_r + 6'h01 : 6'h00;

    // maker , model , serial , revision
    // configuration digits after the model stem
    always_comb begin
        case (idx_r)
            6'h00: idn_char = MAKER_NAME[63:56];
            6'h01: idn_char = MAKER_NAME[55:48];
            6'h02: idn_char = MAKER_NAME[47:40];
            6'h03: idn_char = MAKER_NAME[39:32];
            6'h04: idn_char = MAKER_NAME[31:24];
            6'h05: idn_char = MAKER_NAME[23:16];
            6'h06: idn_char = MAKER_NAME[15:8];
            6'h07: idn_char = MAKER_NAME[7:0];
            6'h09: idn_char = MODEL_STEM[31:24];
            6'h0a: idn_char = MODEL_STEM[23:16];
            6'h0b: idn_char = MODEL_STEM[15:8];
            6'h0c: idn_char = MODEL_STEM[7:0];
            6'h0d: idn_char = ascii_digit({2'h0, CFG_POWER_READ, CFG_PHASE_PROG});
            6'h0e: idn_char = ascii_digit({3'h0, CFG_DUAL_RANGE});
            6'h0f: idn_char = MODEL_TAIL[39:32];
            6'h10: idn_char = MODEL_TAIL[31:24];
            6'h11: idn_char = MODEL_TAIL[23:16];
            6'h12: idn_char = MODEL_TAIL[15:8];
            6'h13: idn_char = MODEL_TAIL[7:0];
            6'h15: idn_char = SERIAL_CHAR;
            6'h17: idn_char = ascii_digit(MAIN_REV_BCD[15:12]);
            6'h18: idn_char = ascii_digit(MAIN_REV_BCD[11:8]);
            6'h19: idn_char = 8'h2e;
            6'h1a: idn_char = ascii_digit(MAIN_REV_BCD[7:4]);
            6'h1b: idn_char = ascii_digit(MAIN_REV_BCD[3:0]);
            6'h1c: idn_char = 8'h2f;
            6'h1d: idn_char = ascii_digit(BUS_REV_BCD[15:12]);
            6'h1e: idn_char = ascii_digit(BUS_REV_BCD[11:8]);
            6'h1f: idn_char = 8'h2e;
            6'h20: idn_char = ascii_digit(BUS_REV_BCD[7:4]);
            6'h21: idn_char = ascii_digit(BUS_REV_BCD[3:0]);
            6'h08, 6'h14, 6'h16: idn_char = 8'h2c;
            default: idn_char = 8'h00;
        endcase
    end

    // numeric answers are one byte; the identification is a byte stream
    // query answers one and does not set the latch
    assign rsp_valid_nxt = is_ese_q || is_esr_q || opcq_done || (st_r == sesacc_pkg::SESACC_ST_IDN);
    assign rsp_last_nxt  = is_ese_q || is_esr_q || opcq_done || idn_end;
    assign rsp_data_nxt  = is_ese_q ? ese_r :
                           is_esr_q ? esr_r :
                           opcq_done ? 8'h01 :
                           (st_r == sesacc_pkg::SESACC_ST_IDN) ? idn_char : 8'h00;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r  <= sesacc_pkg::SESACC_ST_IDLE;
            ese_r <= `SESACC_ESE_RESET;
            esr_r <= `SESACC_ESR_RESET;
            idx_r <= 6'h00;
        end else begin
            st_r  <= st_nxt;
            ese_r <= ese_nxt;
            esr_r <= esr_nxt;
            idx_r <= idx_nxt;
        end
    end

    // summary from next latch and enable values
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            esb_r <= 1'b0;
        end else begin
            esb_r <= |(esr_nxt & ese_nxt);
        end
    end
    assign EVENT_SUMMARY = esb_r;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            CMD_READY <= 1'b1;
            RSP_VALID <= 1'b0;
            RSP_LAST  <= 1'b0;
            RSP_DATA  <= 8'h00;
        end else begin
            CMD_READY <= (st_nxt == sesacc_pkg::SESACC_ST_IDLE);
            RSP_VALID <= rsp_valid_nxt;
            RSP_LAST  <= rsp_last_nxt;
            RSP_DATA  <= rsp_data_nxt;
        end
    end

    // factory defaults on the reset command
    // status byte and amplifier latch cleared outside
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            STATUS_CLEAR  <= 1'b0;
            ENABLES_CLEAR <= 1'b0;
            DFLT_LOAD     <= 1'b0;
            OUT_ON        <= 1'b0;
            RANGE_HIGH    <= 1'b0;
            FREQ_X10      <= `SESACC_FREQ_DFLT;
            PHASE_B_X10   <= `SESACC_PHB_DFLT;
            PHASE_C_X10   <= `SESACC_PHC_DFLT;
        end else begin
            STATUS_CLEAR  <= is_cls;
            ENABLES_CLEAR <= is_rst;
            DFLT_LOAD     <= is_rst;
            if (is_rst) begin
                OUT_ON      <= 1'b0;
                RANGE_HIGH  <= 1'b0;
                FREQ_X10    <= `SESACC_FREQ_DFLT;
                PHASE_B_X10 <= `SESACC_PHB_DFLT;
                PHASE_C_X10 <= `SESACC_PHC_DFLT;
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    wire no_evt = !(EVT_CME || EVT_EXE || EVT_DDE || EVT_QYE);

    sequence idn_begin_s;
        is_idn_q;
    endsequence
    sequence idn_slash_s;
        ##30 (RSP_VALID && RSP_DATA == 8'h2f && !RSP_LAST);
    endsequence

    a_esb_or_enabled: assert property (EVENT_SUMMARY == |(esr_r & ese_r))
        else $error("event summary differs from enabled latch bits");
    a_esb_no_read_effect: assert property (is_ese_q |=> EVENT_SUMMARY == $past(EVENT_SUMMARY) || $changed(esr_r))
        else $error("summary moved without latch change");
    a_ese_readback: assert property ((is_ese_w ##1 !acc ##1 is_ese_q) |=> RSP_DATA == $past(CMD_ARG, 3))
        else $error("enable readback mismatch");
    a_esr_read_clear: assert property ((is_esr_q && no_evt && !opc_done) |=> esr_r == 8'h00 && RSP_DATA == $past(esr_r))
        else $error("latch read did not return then clear");
    a_unused_bits: assert property (esr_r[6] == 1'b0 && esr_r[1] == 1'b0)
        else $error("unused latch bit set");
    a_idn_length: assert property (idn_begin_s |-> ##35 (RSP_VALID && RSP_LAST) ##1 !RSP_VALID)
        else $error("identification length wrong");
    a_idn_config: assert property (idn_begin_s |-> ##15 RSP_DATA[1:0] == $past({CFG_POWER_READ, CFG_PHASE_PROG}))
        else $error("configuration digit wrong");
    a_idn_slash: assert property (idn_begin_s |-> idn_slash_s)
        else $error("revision separator missing");
    a_opc_sets_bit: assert property (opc_done |=> esr_r[`SESACC_BIT_OPC] && CMD_READY)
        else $error("completion bit not set");
    a_opc_waits: assert property ((st_r == sesacc_pkg::SESACC_ST_OPCW && OP_BUSY) |=> !CMD_READY)
        else $error("new command taken while operations pending");
    a_opc_summary: assert property ((opc_done && ese_r[0] && !is_rst) |=> EVENT_SUMMARY)
        else $error("completion did not raise summary");
    a_rst_defaults: assert property (is_rst |=> DFLT_LOAD && ENABLES_CLEAR && ese_r == 8'h00 && FREQ_X10 == 16'h0fa0)
        else $error("defaults not restored");
    a_rst_keeps_latch: assert property ((is_rst && no_evt && !opc_done) |=> esr_r == $past(esr_r))
        else $error("reset command changed latch");
    a_cls_clears: assert property ((is_cls && no_evt && !opc_done) |=> esr_r == 8'h00 && STATUS_CLEAR)
        else $error("clear-status incomplete");
    a_opcq_answer: assert property (opcq_done |=> RSP_VALID && RSP_LAST && RSP_DATA == 8'h01 && esr_r[0] == $past(esr_r[0]))
        else $error("completion query answer wrong");

endmodule // sesacc_core

`default_nettype wire

// *** src/sesacc_params.svh ***
`ifndef SESACC_PARAMS_SVH
`define SESACC_PARAMS_SVH

// bit positions shared by the event latch and the event enable register
`define SESACC_BIT_OPC      0
`define SESACC_BIT_QYE      2
`define SESACC_BIT_DDE      3
`define SESACC_BIT_EXE      4
`define SESACC_BIT_CME      5
`define SESACC_BIT_PON      7

// reset values
`define SESACC_ESE_RESET    8'h00
// power-on event is latched by the reset itself
`define SESACC_ESR_RESET    8'h80

// identification stream layout (byte indices)
`define SESACC_IDN_LEN      6'h22
`define SESACC_IDN_LAST     6'h21
`define SESACC_IDN_D5_IDX   6'h0d
`define SESACC_IDN_SLASH    6'h1c

// defaults in tenths: 400.0, 120.0, 240.0
`define SESACC_FREQ_DFLT    16'h0fa0
`define SESACC_PHB_DFLT     16'h04b0
`define SESACC_PHC_DFLT     16'h0960

`endif

// *** src/sesacc_pkg.sv ***
`default_nettype none
package sesacc_pkg;

    typedef enum logic [3:0] {
        SESACC_CMD_NOP   = 4'h0,
        SESACC_CMD_ESE_W = 4'h1,
        SESACC_CMD_ESE_Q = 4'h2,
        SESACC_CMD_ESR_Q = 4'h3,
        SESACC_CMD_IDN_Q = 4'h4,
        SESACC_CMD_OPC   = 4'h5,
        SESACC_CMD_OPC_Q = 4'h6,
        SESACC_CMD_RST   = 4'h7,
        SESACC_CMD_CLS   = 4'h8
    } sesacc_cmd_t;

    typedef enum logic [3:0] {
        SESACC_ST_IDLE  = 4'b0001,
        SESACC_ST_OPCW  = 4'b0010,
        SESACC_ST_OPCQW = 4'b0100,
        SESACC_ST_IDN   = 4'b1000
    } sesacc_state_t;

endpackage

`default_nettype wire

// *** verif/sesacc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// host side of the command port: one strobe per command, after waiting up to 200 cycles for ready
module sesacc_host (
    input  wire logic       clk,
    input  wire logic       cmd_ready,
    output var  logic       cmd_valid,
    output var  logic [3:0] cmd_code,
    output var  logic [7:0] cmd_arg
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 4'h0;
        cmd_arg   = 8'h00;
    end
    task automatic send(input logic [3:0] code, input logic [7:0] arg, output logic took);
        int n;
        n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        took = (cmd_ready === 1'b1);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_arg = arg;
        @(posedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        // released lines must not keep looking like the last command
        cmd_code = ~code;
        cmd_arg = ~arg;
    endtask
endmodule // sesacc_host
`default_nettype wire

// *** verif/tb_standard_event_status_and_common_cmds.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_standard_event_status_and_common_cmds;
    logic        clk, resetn, cmd_valid, cmd_ready, op_busy, took;
    logic [3:0]  cmd_code, evt;
    logic [7:0]  cmd_arg, rsp_data, v;
    logic [2:0]  cfg;
    logic [15:0] main_rev, bus_rev, freq, ph_b, ph_c;
    logic        rsp_valid, rsp_last, summ, st_clr, en_clr, dflt, out_on, rng_hi;
    logic [271:0] idn;
    logic [8:0]  expq[$];
    int          n_fail, comparisons, cycles;

    sesacc_host host (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_arg(cmd_arg));
    sesacc_core dut (.CLK(clk), .RESETN(resetn), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
        .CMD_ARG(cmd_arg), .CMD_READY(cmd_ready), .OP_BUSY(op_busy), .EVT_CME(evt[3]), .EVT_EXE(evt[2]),
        .EVT_DDE(evt[1]), .EVT_QYE(evt[0]), .CFG_PHASE_PROG(cfg[0]), .CFG_POWER_READ(cfg[1]),
        .CFG_DUAL_RANGE(cfg[2]), .MAIN_REV_BCD(main_rev), .BUS_REV_BCD(bus_rev), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .RSP_LAST(rsp_last), .EVENT_SUMMARY(summ), .STATUS_CLEAR(st_clr),
        .ENABLES_CLEAR(en_clr), .DFLT_LOAD(dflt), .OUT_ON(out_on), .RANGE_HIGH(rng_hi), .FREQ_X10(freq),
        .PHASE_B_X10(ph_b), .PHASE_C_X10(ph_c));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic test_done();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [47:0] got, input logic [47:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rsp(input logic [8:0] got);
        logic [8:0] exp;
        exp = (expq.size() > 0) ? expq.pop_front() : ~got;
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t answer byte got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [3:0] code, input logic [7:0] arg);
        host.send(code, arg, took);
        if (took !== 1'b1) begin
            n_fail++;
            $display("BAD %0t command port never ready", $time);
        end
    endtask

    // note the single answer byte first, the watcher pairs it up
    task automatic query(input logic [3:0] code, input logic [7:0] exp);
        expq.push_back({1'b1, exp});
        cmd(code, 8'h00);
    endtask

    task automatic pulse(input logic [3:0] e);
        evt = e;
        @(negedge clk);
        evt = 4'h0;
        repeat (2) @(negedge clk);
    endtask

    // answer bytes are looked at mid-cycle, away from the edge that launches them
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            chk_rsp({rsp_last, rsp_data});
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'h0a5214cf));
        resetn = 1'b0;
        op_busy = 1'b0;
        evt = 4'h0;
        cfg = 3'($urandom());
        for (int i = 0; i < 4; i++) begin
            main_rev[i*4+:4] = 4'($urandom_range(9));
            bus_rev[i*4+:4] = 4'($urandom_range(9));
        end
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        chk_val({freq, ph_b, ph_c}, {16'h0fa0, 16'h04b0, 16'h0960}, "defaults");
        chk_val({out_on, rng_hi, summ}, 3'b000, "reset levels");
        query(4'h3, 8'h80);
        query(4'h3, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom());
            cmd(4'h1, v);
            query(4'h2, v);
        end
        for (int b = 0; b < 4; b++) begin
            v = 8'h01 << (5 - b);
            cmd(4'h1, v);
            pulse(4'h8 >> b);
            chk_val(summ, 1'b1, "summary on");
            cmd(4'h1, ~v);
            @(negedge clk);
            chk_val(summ, 1'b0, "summary masked");
            query(4'h3, v);
            cmd(4'h1, v);
            @(negedge clk);
            chk_val(summ, 1'b0, "summary after read");
        end
        cmd(4'h1, 8'h01);
        op_busy = 1'b1;
        cmd(4'h5, 8'h00);
        repeat (8) @(negedge clk);
        chk_val({summ, cmd_ready}, 2'b00, "complete too early");
        op_busy = 1'b0;
        repeat (3) @(negedge clk);
        chk_val(summ, 1'b1, "complete summary");
        query(4'h3, 8'h01);
        op_busy = 1'b1;
        query(4'h6, 8'h01);
        repeat (5) @(negedge clk);
        op_busy = 1'b0;
        query(4'h3, 8'h00);
        cmd(4'h1, 8'hbd);
        pulse(4'h8);
        cmd(4'h7, 8'h00);
        chk_val({dflt, en_clr}, 2'b11, "reset pulses");
        chk_val({freq, ph_b, ph_c, out_on, rng_hi}, {16'h0fa0, 16'h04b0, 16'h0960, 2'b00}, "defaults");
        query(4'h2, 8'h00);
        query(4'h3, 8'h20);
        pulse(4'h1);
        cmd(4'h8, 8'h00);
        chk_val(st_clr, 1'b1, "clear pulse");
        query(4'h3, 8'h00);
        idn = {"ACME LAB,ACS-", 6'h0c, cfg[1:0], 7'h18, cfg[2], "010.1,0,", 4'h3, main_rev[15:12],
            4'h3, main_rev[11:8], ".", 4'h3, main_rev[7:4], 4'h3, main_rev[3:0], "/", 4'h3,
            bus_rev[15:12], 4'h3, bus_rev[11:8], ".", 4'h3, bus_rev[7:4], 4'h3, bus_rev[3:0]};
        for (int i = 33; i >= 0; i--) begin
            expq.push_back({i == 0, idn[i*8+:8]});
        end
        cmd(4'h4, 8'h00);
        repeat (40) @(negedge clk);
        chk_val(48'(expq.size()), 48'h0, "answers left over");
        test_done();
    end
endmodule // tb_standard_event_status_and_common_cmds
`default_nettype wire
